/* verilog/adsc_regs.svh */
// offsets, field positions, reset values and timing counts of the block
`ifndef ADSC_REGS_SVH
`define ADSC_REGS_SVH

`define ADSC_CTRL_OFS      12'h000
`define ADSC_RESULT_OFS    12'h004
`define ADSC_STAT_OFS      12'h008

`define ADSC_CTRL_EN       0
`define ADSC_CTRL_START    1
`define ADSC_CTRL_CH       2
`define ADSC_CTRL_NEG      5
`define ADSC_CTRL_VCCREF   8
`define ADSC_CTRL_BGREF    9
`define ADSC_CTRL_PASS     10
`define ADSC_CTRL_RST      32'h00000400

`define ADSC_STAT_BUSY     0
`define ADSC_STAT_DONE     1
`define ADSC_STAT_READY    2

`define ADSC_SCAN_LEN      36
`define ADSC_B_VCCREF      0
`define ADSC_B_SETTLE      1
`define ADSC_B_LATCH_PRECHARGE_N_N     2
`define ADSC_B_PASS        3
`define ADSC_B_NEG         4
`define ADSC_B_MUX         7
`define ADSC_B_BGREF       15
`define ADSC_B_HOLD        16
`define ADSC_B_GNDNEG      17
`define ADSC_B_BYPASS      18
`define ADSC_B_DAC         19
`define ADSC_B_AMPON       29
`define ADSC_B_CONVON      30
`define ADSC_B_BGNEG       31
`define ADSC_B_SPARE       32
`define ADSC_B_AMPPATH     33
`define ADSC_B_AMPCLK      34
`define ADSC_B_COMP        35
`define ADSC_IDLE_VEC      36'h01005008c

`define ADSC_DAC_MID       10'h200
`define ADSC_CLK_NS        100
`define ADSC_SAMPLE_NS     1500
`define ADSC_POWERUP_NS    200
`define ADSC_SAMPLE_CYC    ((`ADSC_SAMPLE_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)
`define ADSC_POWERUP_CYC   ((`ADSC_POWERUP_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)

`endif

/* verilog/adsc_pkg.sv */
// types shared by the converter control block
package adsc_pkg;
  typedef enum logic [2:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_LATCH_PRECHARGE_N,
    SAR_SETTLE,
    SAR_EVAL
  } adsc_sar_state_t;
endpackage

/* verilog/adsc_sar.sv */
// successive approximation sequencer driving the dac and reading comp
`timescale 1ns/1ps
`include "adsc_regs.svh"
module adsc_sar
  import adsc_pkg::*;
#(
  parameter int WIDTH      = 10,
  parameter int SAMPLE_CYC = `ADSC_SAMPLE_CYC
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire logic             comp,
  output logic [WIDTH-1:0]      dac_q,
  output logic                  hold_q,
  output logic                  latch_precharge_n_n_q,
  output logic                  busy,
  output logic                  done_q,
  output logic [WIDTH-1:0]      result_q
);
  localparam logic [WIDTH-1:0] MID = WIDTH'(1) << (WIDTH - 1);

  if (WIDTH < 2 || WIDTH > 16 || SAMPLE_CYC < 1 || SAMPLE_CYC > 255) begin
    $error("adsc_sar: unsupported WIDTH or SAMPLE_CYC");
  end

  adsc_sar_state_t st_q, st_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [WIDTH-1:0] dac_d, result_d;
  logic             hold_d, latch_precharge_n_n_d, done_d;

  assign busy = (st_q != SAR_IDLE);

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    bit_d     = bit_q;
    dac_d     = dac_q;
    hold_d    = hold_q;
    latch_precharge_n_n_d = latch_precharge_n_n_q;
    result_d  = result_q;
    done_d    = 1'b0;
    case (st_q)
      SAR_IDLE: begin
        if (start) begin
          st_d   = SAR_SAMPLE;
          hold_d = 1'b0;                                    // [R1]
          dac_d  = MID;                                     // [R13]
          cnt_d  = 8'(SAMPLE_CYC - 1);
        end
      end
      SAR_SAMPLE: begin
        if (cnt_q == 8'h00) begin
          hold_d    = 1'b1;                                 // [R1]
          dac_d     = MID;
          bit_d     = 4'(WIDTH - 1);
          latch_precharge_n_n_d = 1'b0;                                 // [R3]
          st_d      = SAR_LATCH_PRECHARGE_N;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      SAR_LATCH_PRECHARGE_N: begin
        latch_precharge_n_n_d = 1'b1;                                   // [R3]
        st_d      = SAR_SETTLE;
      end
      SAR_SETTLE: begin
        st_d = SAR_EVAL;
      end
      SAR_EVAL: begin
        // comparator high means the trial code is above the input
        if (comp) begin
          dac_d[bit_q] = 1'b0;                              // [R11]
        end
        if (bit_q == 4'h0) begin
          result_d = dac_d;
          done_d   = 1'b1;
          dac_d    = MID;
          st_d     = SAR_IDLE;
        end else begin
          bit_d        = bit_q - 4'h1;
          dac_d[bit_d] = 1'b1;                              // [R11]
          latch_precharge_n_n_d    = 1'b0;
          st_d         = SAR_LATCH_PRECHARGE_N;
        end
      end
      default: st_d = SAR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q      <= SAR_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= 4'h0;
      dac_q     <= MID;
      hold_q    <= 1'b1;
      latch_precharge_n_n_q <= 1'b1;
      done_q    <= 1'b0;
      result_q  <= '0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      dac_q     <= dac_d;
      hold_q    <= hold_d;
      latch_precharge_n_n_q <= latch_precharge_n_n_d;
      done_q    <= done_d;
      result_q  <= result_d;
    end
  end

  AST_SAMPLE_BOUNDED: assert property (@(posedge clk) // [R1]
    disable iff (srst) $fell(hold_q) |-> !hold_q ##[1:300] $rose(hold_q))
    else $error("sample phase did not end in time");
  AST_SAMPLE_MID: assert property (@(posedge clk) disable iff (srst) // [R13]
    !hold_q |-> dac_q == MID)
    else $error("dac code moved while sampling");
  AST_LATCH_PRECHARGE_N_PULSE: assert property (@(posedge clk) disable iff (srst) // [R3]
    $fell(latch_precharge_n_n_q) |=> latch_precharge_n_n_q ##1 latch_precharge_n_n_q)
    else $error("precharge not one cycle followed by evaluation");
  AST_CONV_ENDS: assert property (@(posedge clk) disable iff (srst) // [R11]
    (start && st_q == SAR_IDLE) |-> ##[30:1000] done_q)
    else $error("conversion did not complete");
  AST_DONE_STATE: assert property (@(posedge clk) disable iff (srst) // [R11]
    done_q |-> hold_q && latch_precharge_n_n_q && dac_q == MID && !busy)
    else $error("done without returning to idle");
  COV_CONVERSION: cover property (@(posedge clk) disable iff (srst)
    $rose(busy) ##[1:1000] done_q);
endmodule

/* verilog/adsc_top.sv */
// converter control: apb registers, boundary-scan cells, sar sequencer
// Function
// R1 - hold low tracks input, high freezes it
// R2 - tester raises hold only while amp clock high; the bench raises hold with amp_clock left low
// R3 - precharge comparator latch while precharge input low
// R4 - tester may assist settling two amp clocks
// R5 - three-bit negative input mux select
// R6 - supply reference select picks supply reference
// R7 - passgate conducts while its enable asserted
// R8 - tester selects only one negative source
// R9 - tester drives documented idle values when unused
// R10 - tester should avoid switch-cap amplifier in scan
// R11 - normal results from successive approximation logic
// R12 - tester checks lower then upper limit code
// R13 - dac held at midpoint while sampling
// R14 - converter power-on qualifies all other controls
// R15 - controls take scan cell value at update
// R16 - comparator captured into its cell at capture
`timescale 1ns/1ps
`include "adsc_regs.svh"
module adsc_top
  import adsc_pkg::*;
#(
  parameter int DAC_W      = 10,
  parameter int SAMPLE_CYC = `ADSC_SAMPLE_CYC
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         scan_mode,
  input  wire logic         scan_capture,
  input  wire logic         scan_shift,
  input  wire logic         scan_update,
  input  wire logic         scan_in,
  output logic              scan_out,
  input  wire logic         comp,
  output logic              sample_hold,
  output logic              latch_precharge_n,
  output logic              settle_assist,
  output logic              amp_power_on,
  output logic      [7:0]   input_select_bits,
  output logic      [2:0]   negative_input_select,
  output logic              supply_reference_select,
  output logic              bandgap_dac_reference_enable,
  output logic              amp_passgate_enable,
  output logic              switchcap_test_route,
  output logic              converter_power_on,
  output logic      [9:0]   dac_code,
  output logic              bypass_enable,
  output logic              ground_neg_enable,
  output logic              bandgap_neg_enable,
  output logic              amp_path_enable,
  output logic              amp_clock
);
  localparam int N = `ADSC_SCAN_LEN;

  if (DAC_W != 10) begin
    $error("adsc_top: scan cell layout serves a 10-bit dac only");
  end

  function automatic logic [7:0] ch_onehot(input logic [2:0] ch);
    ch_onehot = 8'h01 << ch;
  endfunction

  // register group
  logic [31:0] ctrl_q, ctrl_d, prdata_q, prdata_d;
  logic        start_q, start_d, done_st_q, done_st_d, slverr_q, slverr_d;
  logic [7:0]  pwr_q, pwr_d;
  // scan group
  logic [N-1:0] chain_q, chain_d, upd_q, upd_d, out_q, out_d, func;

  logic             sar_busy, sar_done, sar_hold, sar_latch_precharge_n_n;
  logic [DAC_W-1:0] sar_dac, sar_result;
  logic             en, pwr_ready, wr, setup;

  assign en        = ctrl_q[`ADSC_CTRL_EN];
  assign pwr_ready = (pwr_q == 8'(`ADSC_POWERUP_CYC));
  assign wr        = psel && penable && pwrite;
  assign setup     = psel && !penable;
  assign pready    = psel && penable;
  assign prdata    = prdata_q;
  assign pslverr   = slverr_q && pready;

  always_comb begin
    ctrl_d    = ctrl_q;
    start_d   = 1'b0;
    done_st_d = done_st_q;
    prdata_d  = prdata_q;
    slverr_d  = slverr_q;
    pwr_d     = pwr_q;
    if (!en) begin
      pwr_d = 8'h00;                                        // [R14]
    end else if (!pwr_ready) begin
      pwr_d = pwr_q + 8'h01;
    end
    if (setup) begin
      slverr_d = 1'b0;
      prdata_d = 32'h0;
      if (paddr == `ADSC_CTRL_OFS) begin
        prdata_d = ctrl_q;
      end else if (paddr == `ADSC_RESULT_OFS) begin
        prdata_d[DAC_W-1:0] = sar_result;
      end else if (paddr == `ADSC_STAT_OFS) begin
        prdata_d[`ADSC_STAT_BUSY]  = sar_busy;
        prdata_d[`ADSC_STAT_DONE]  = done_st_q;
        prdata_d[`ADSC_STAT_READY] = en && pwr_ready;
      end else begin
        slverr_d = 1'b1;
      end
    end
    if (wr && paddr == `ADSC_CTRL_OFS) begin
      ctrl_d = pwdata & 32'h000007fd;
      start_d = pwdata[`ADSC_CTRL_START] && en && pwr_ready
                && !sar_busy && !scan_mode;                 // [R14]
    end
    if (wr && paddr == `ADSC_STAT_OFS && pwdata[`ADSC_STAT_DONE]) begin
      done_st_d = 1'b0;
    end
    if (sar_done) begin
      done_st_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q    <= `ADSC_CTRL_RST;
      start_q   <= 1'b0;
      done_st_q <= 1'b0;
      prdata_q  <= 32'h0;
      slverr_q  <= 1'b0;
      pwr_q     <= 8'h00;
    end else begin
      ctrl_q    <= ctrl_d;
      start_q   <= start_d;
      done_st_q <= done_st_d;
      prdata_q  <= prdata_d;
      slverr_q  <= slverr_d;
      pwr_q     <= pwr_d;
    end
  end

  adsc_sar #(
    .WIDTH      (DAC_W),
    .SAMPLE_CYC (SAMPLE_CYC)
  ) u_sar (
    .clk        (clk),
    .srst       (srst),
    .start      (start_q),
    .comp       (comp),
    .dac_q      (sar_dac),
    .hold_q     (sar_hold),
    .latch_precharge_n_n_q  (sar_latch_precharge_n_n),
    .busy       (sar_busy),
    .done_q     (sar_done),
    .result_q   (sar_result)
  );

  always_comb begin
    func = `ADSC_IDLE_VEC;
    if (en) begin
      func[`ADSC_B_CONVON]              = 1'b1;             // [R14]
      func[`ADSC_B_DAC +: 10]           = sar_dac;          // [R11]
      func[`ADSC_B_HOLD]                = sar_hold;         // [R1]
      func[`ADSC_B_LATCH_PRECHARGE_N_N]             = sar_latch_precharge_n_n;      // [R3]
      func[`ADSC_B_MUX +: 8]            =
        ch_onehot(ctrl_q[`ADSC_CTRL_CH +: 3]);
      func[`ADSC_B_NEG +: 3]            = ctrl_q[`ADSC_CTRL_NEG +: 3]; // [R5]
      func[`ADSC_B_VCCREF]              = ctrl_q[`ADSC_CTRL_VCCREF]; // [R6]
      func[`ADSC_B_BGREF]               = ctrl_q[`ADSC_CTRL_BGREF];
      func[`ADSC_B_PASS]                = ctrl_q[`ADSC_CTRL_PASS]; // [R7]
    end
    out_d = scan_mode ? upd_q : func;                       // [R15]
    out_d[`ADSC_B_COMP] = 1'b0;
    chain_d = chain_q;
    upd_d   = upd_q;
    if (scan_capture) begin
      chain_d = out_q;
      chain_d[`ADSC_B_COMP] = comp;                         // [R16]
    end else if (scan_shift) begin
      chain_d = {scan_in, chain_q[N-1:1]};
    end else if (scan_update) begin
      upd_d = chain_q;                                      // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      chain_q <= `ADSC_IDLE_VEC;
      upd_q   <= `ADSC_IDLE_VEC;                            // [R9]
      out_q   <= `ADSC_IDLE_VEC;
    end else begin
      chain_q <= chain_d;
      upd_q   <= upd_d;
      out_q   <= out_d;
    end
  end

  assign scan_out                     = chain_q[0];
  assign supply_reference_select      = out_q[`ADSC_B_VCCREF];
  assign settle_assist                = out_q[`ADSC_B_SETTLE];
  assign latch_precharge_n            = out_q[`ADSC_B_LATCH_PRECHARGE_N_N];
  assign amp_passgate_enable          = out_q[`ADSC_B_PASS];
  assign negative_input_select        = out_q[`ADSC_B_NEG +: 3];
  assign input_select_bits            = out_q[`ADSC_B_MUX +: 8];
  assign bandgap_dac_reference_enable = out_q[`ADSC_B_BGREF];
  assign sample_hold                  = out_q[`ADSC_B_HOLD];
  assign ground_neg_enable            = out_q[`ADSC_B_GNDNEG];
  assign bypass_enable                = out_q[`ADSC_B_BYPASS];
  assign dac_code                     = out_q[`ADSC_B_DAC +: 10];
  assign amp_power_on                 = out_q[`ADSC_B_AMPON];
  assign converter_power_on           = out_q[`ADSC_B_CONVON];
  assign bandgap_neg_enable           = out_q[`ADSC_B_BGNEG];
  assign switchcap_test_route         = out_q[`ADSC_B_SPARE];
  assign amp_path_enable              = out_q[`ADSC_B_AMPPATH];
  assign amp_clock                    = out_q[`ADSC_B_AMPCLK];

  AST_UPDATE_LOADS: assert property (@(posedge clk) disable iff (srst) // [R15]
    (scan_update && !scan_capture && !scan_shift) |=>
      upd_q == $past(chain_q))
    else $error("update latch did not take the chain value");
  AST_SCAN_DRIVES: assert property (@(posedge clk) disable iff (srst) // [R15]
    (scan_mode && $past(scan_mode)) |->
      sample_hold == $past(upd_q[`ADSC_B_HOLD]) &&
      dac_code == $past(upd_q[`ADSC_B_DAC +: 10]))
    else $error("control pins do not follow the update latch");
  AST_CAPTURE_COMP: assert property (@(posedge clk) disable iff (srst) // [R16]
    scan_capture |=> chain_q[`ADSC_B_COMP] == $past(comp))
    else $error("comparator not captured");
  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (srst) // [R14]
    (!scan_mode && !en) |=> !converter_power_on && sample_hold &&
      dac_code == `ADSC_DAC_MID)
    else $error("controls not idle while converter off");
  AST_VCCREF: assert property (@(posedge clk) disable iff (srst) // [R6]
    (!scan_mode && en) |=>
      supply_reference_select == $past(ctrl_q[`ADSC_CTRL_VCCREF]))
    else $error("supply reference select wrong");
  AST_PASSGATE: assert property (@(posedge clk) disable iff (srst) // [R7]
    (!scan_mode && en) |=>
      amp_passgate_enable == $past(ctrl_q[`ADSC_CTRL_PASS]))
    else $error("passgate enable wrong");
  AST_NEGATIVE_INPUT_SELECT: assert property (@(posedge clk) disable iff (srst) // [R5]
    (!scan_mode && en) |=>
      negative_input_select == $past(ctrl_q[`ADSC_CTRL_NEG +: 3]))
    else $error("negative input select wrong");
  AST_MUX_ONEHOT: assert property (@(posedge clk) disable iff (srst) // [R14]
    (!scan_mode && en) |=> $onehot(input_select_bits))
    else $error("input select not one-hot");
  COV_SCAN_UPDATE: cover property (@(posedge clk) disable iff (srst)
    scan_mode && scan_update);
  COV_CAPTURE_HIGH: cover property (@(posedge clk) disable iff (srst)
    scan_capture && comp);
  COV_START: cover property (@(posedge clk) disable iff (srst) start_q);
endmodule

/* verification/adsc_analog_model.sv */
// behavioural analog side: sample/hold capacitor and output comparator
`timescale 1ns/1ps
module adsc_analog_model (
  input  wire logic       clk,
  input  wire logic [9:0] vin,
  input  wire logic       sample_hold,
  input  wire logic       latch_precharge_n,
  input  wire logic       converter_power_on,
  input  wire logic [9:0] dac_code,
  output logic            comp
);
  logic [9:0] held_q = 10'h000;

  // tracks while hold is low, frozen while high
  always @(posedge clk) begin
    if (!sample_hold) begin
      held_q <= vin;
    end
  end

  // high while powered, latch_precharge_n high and the dac code above the held input
  assign comp = converter_power_on & latch_precharge_n
                & (dac_code > held_q);
endmodule

/* verification/adc_scan_control_signals_tb.sv */
// self-checking bench: apb registers, sar conversion, scan limit check
`timescale 1ns/1ps
`include "adsc_regs.svh"
module adc_scan_control_signals_tb
  import adsc_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        scan_mode = 1'b0, scan_capture = 1'b0, scan_in = 1'b0;
  logic        scan_shift = 1'b0, scan_update = 1'b0;
  logic [9:0]  vin = 10'h000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, scan_out, comp, err;
  logic        sample_hold, latch_precharge_n, settle_assist, amp_power_on;
  logic [7:0]  input_select_bits;
  logic [2:0]  negative_input_select;
  logic        supply_reference_select, bandgap_dac_reference_enable;
  logic        amp_passgate_enable, switchcap_test_route;
  logic        converter_power_on, bypass_enable, ground_neg_enable;
  logic        bandgap_neg_enable, amp_path_enable, amp_clock;
  logic [9:0]  dac_code;
  logic [35:0] prev_v, got;
  int          num_errors = 0;
  int          checks = 0;

  always #50 clk = ~clk;

  adsc_top #(.SAMPLE_CYC(4)) u_dut (
    .clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .scan_mode, .scan_capture, .scan_shift,
    .scan_update, .scan_in, .scan_out, .comp, .sample_hold,
    .latch_precharge_n, .settle_assist, .amp_power_on, .input_select_bits,
    .negative_input_select, .supply_reference_select,
    .bandgap_dac_reference_enable, .amp_passgate_enable,
    .switchcap_test_route, .converter_power_on, .dac_code, .bypass_enable,
    .ground_neg_enable, .bandgap_neg_enable, .amp_path_enable, .amp_clock
  );

  adsc_analog_model u_model (
    .clk, .vin, .sample_hold, .latch_precharge_n, .converter_power_on,
    .dac_code, .comp
  );

  function automatic logic [35:0] outs();
    return {1'b0, amp_clock, amp_path_enable, switchcap_test_route,
            bandgap_neg_enable, converter_power_on, amp_power_on, dac_code,
            bypass_enable, ground_neg_enable, sample_hold,
            bandgap_dac_reference_enable, input_select_bits,
            negative_input_select, amp_passgate_enable, latch_precharge_n,
            settle_assist, supply_reference_select};
  endfunction

  // one negative source only, amplifier path left unused
  // amplifier clock and settle assist stay low with it
  function automatic logic [35:0] mk(input logic hold, input logic pre_n,
                                     input logic [9:0] dac);
    logic [35:0] v;
    v = `ADSC_IDLE_VEC;
    v[`ADSC_B_CONVON] = 1'b1;
    v[`ADSC_B_MUX +: 8] = 8'h08;
    v[`ADSC_B_HOLD] = hold;
    v[`ADSC_B_LATCH_PRECHARGE_N_N] = pre_n;
    v[`ADSC_B_DAC +: 10] = dac;
    return v;
  endfunction

  task automatic chk(input string what, input logic [35:0] seen,
                     input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      chk("pready", 1'b0, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADSC_STAT_OFS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    chk("status poll", rd[b], 1'b1);
  endtask

  // capture, shift 36 cells in, update, then compare pins and capture
  task automatic sl(input logic [35:0] v);
    @(posedge clk);
    scan_capture <= 1'b1;
    for (int i = 0; i < 36; i++) begin
      @(posedge clk);
      if (i > 0) begin
        got[i-1] = scan_out;
      end
      scan_capture <= 1'b0;
      scan_shift <= 1'b1;
      scan_in <= v[i];
    end
    @(posedge clk);
    got[35] = scan_out;
    scan_shift <= 1'b0;
    scan_update <= 1'b1;
    @(posedge clk);
    scan_update <= 1'b0;
    repeat (3) @(posedge clk);
    chk("captured cells", {1'b0, got[34:0]}, {1'b0, prev_v[34:0]});
    chk("pins after update", outs(), {1'b0, v[34:0]});
    prev_v = v;
  endtask

  task automatic limit(input logic [9:0] lim, input logic exp);
    sl(mk(1'b0, 1'b1, `ADSC_DAC_MID));
    sl(mk(1'b1, 1'b1, `ADSC_DAC_MID));
    sl(mk(1'b1, 1'b1, lim));
    sl(mk(1'b1, 1'b0, lim));
    sl(mk(1'b1, 1'b1, lim));
    chk("comp while precharged", got[35], 1'b0);
    sl(mk(1'b1, 1'b1, `ADSC_DAC_MID));
    chk("comp at limit", got[35], exp);
  endtask

  always @(posedge clk) begin
    if (!srst && sample_hold === 1'b0) begin
      chk("dac while sampling", dac_code, `ADSC_DAC_MID);
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("idle outputs", outs(), `ADSC_IDLE_VEC);
    rdchk("ctrl reset", `ADSC_CTRL_OFS, `ADSC_CTRL_RST);
    apb(1'b1, `ADSC_CTRL_OFS, 32'h2);
    rdchk("start while off", `ADSC_STAT_OFS, 32'h0);
    apb(1'b1, `ADSC_RESULT_OFS, 32'h3ff);
    rdchk("result read only", `ADSC_RESULT_OFS, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers finished");
    vin <= 10'h2a5;
    apb(1'b1, `ADSC_CTRL_OFS, 32'h7ad);
    rdchk("ctrl readback", `ADSC_CTRL_OFS, 32'h7ad);
    chk("input mux", input_select_bits, 8'h08);
    chk("bandgap dac ref", bandgap_dac_reference_enable, 1'b1);
    chk("negative select", negative_input_select, 3'h5);
    chk("supply reference", supply_reference_select, 1'b1);
    chk("passgate", amp_passgate_enable, 1'b1);
    chk("converter on", converter_power_on, 1'b1);
    poll(`ADSC_STAT_READY);
    apb(1'b1, `ADSC_CTRL_OFS, 32'h7af);
    poll(`ADSC_STAT_DONE);
    rdchk("result", `ADSC_RESULT_OFS, 32'h2a5);
    apb(1'b1, `ADSC_STAT_OFS, 32'h2);
    rdchk("done cleared", `ADSC_STAT_OFS, 32'h4);
    $display("test conversion finished");
    vin <= 10'h130;
    scan_mode <= 1'b1;
    repeat (3) @(posedge clk);
    prev_v = outs();
    chk("scan latch idle", prev_v, `ADSC_IDLE_VEC);
    apb(1'b1, `ADSC_CTRL_OFS, 32'h7af);
    rdchk("start refused in scan", `ADSC_STAT_OFS, 32'h4);
    limit(10'h123, 1'b0);
    limit(10'h143, 1'b1);
    $display("test scan limit check finished");
    give_verdict();
  end
endmodule
